//--- core/irc_pkg.sv
// shared constants and types for the interrupt request classifier
`default_nettype none
package irc_pkg;
  localparam int DEF_NUM_SRC = 32;
  localparam int DEF_NUM_SLOT = 16;
  localparam int MAX_NUM_SRC = 32;
  localparam int MAX_NUM_SLOT = 32;
  typedef enum logic [1:0] {
    IRC_CLS_NONE,
    IRC_CLS_FAST,
    IRC_CLS_VECT,
    IRC_CLS_PLAIN
  } irc_class_t;
endpackage
`default_nettype wire

//--- core/irc_slot_pick.sv
// picks the highest-priority (lowest numbered) active vectored slot
`default_nettype none
module irc_slot_pick #(
  parameter int N = 16,
  parameter int IW = 4
) (
  input wire logic [N-1:0] hits,
  output logic any,
  output logic [IW-1:0] idx
);
  generate
    if (N < 2 || IW < $clog2(N)) begin : g_bad
      $error("irc_slot_pick: slot index too narrow for the slot count");
    end
  endgenerate

  function automatic logic [IW-1:0] irc_first(input logic [N-1:0] v);
    logic [IW-1:0] r;
    r = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IW'(i);
      end
    end
    return r;
  endfunction

  always_comb begin
    any = |hits;
    idx = irc_first(hits);
  end
endmodule
`default_nettype wire

//--- core/irc_classifier.sv
// interrupt request classifier: sorts requests into fast, vectored and plain normal classes
//
// Notes on behaviour
// - every enabled request lands in exactly one class: fast, vectored or plain normal.
// - class and slot priority inputs may change anytime; effect next clock with clk_en high, no reset.
// - fast requests take precedence over every normal request presented.
// - all active fast-class sources are ORed onto the single fast request output.
// - a readable word shows, one bit per source, which fast sources are requesting.
`default_nettype none
module irc_classifier #(
  parameter int NUM_SRC = irc_pkg::DEF_NUM_SRC,
  parameter int NUM_SLOT = irc_pkg::DEF_NUM_SLOT,
  parameter int SW = $clog2(NUM_SRC),
  parameter int LW = $clog2(NUM_SLOT)
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [NUM_SRC-1:0] req_in,
  input wire logic [NUM_SRC-1:0] src_enable,
  input wire logic [NUM_SRC-1:0] fast_select,
  input wire logic [NUM_SLOT-1:0] slot_enable,
  input wire logic [NUM_SLOT*SW-1:0] slot_source,
  output logic fast_req,
  output logic normal_req,
  output logic [NUM_SRC-1:0] fast_status,
  output logic [NUM_SRC-1:0] vect_status,
  output logic [NUM_SRC-1:0] plain_status,
  output logic vect_valid,
  output logic [LW-1:0] vect_slot,
  output irc_pkg::irc_class_t present_class
);
  generate
    if (NUM_SRC < 2 || NUM_SRC > irc_pkg::MAX_NUM_SRC || NUM_SLOT < 2 || NUM_SLOT > irc_pkg::MAX_NUM_SLOT) begin : g_bad
      $error("irc_classifier: source or slot count out of range");
    end
    // derived widths; an override that disagrees would mis-slice the slot table
    if (SW != $clog2(NUM_SRC) || LW != $clog2(NUM_SLOT)) begin : g_bad_width
      $error("irc_classifier: index widths do not match the counts");
    end
  endgenerate

  typedef struct packed {
    logic fast_req;
    logic normal_req;
    logic [NUM_SRC-1:0] fast_status;
    logic [NUM_SRC-1:0] vect_status;
    logic [NUM_SRC-1:0] plain_status;
    logic vect_valid;
    logic [LW-1:0] vect_slot;
    irc_pkg::irc_class_t present_class;
  } irc_state_t;

  irc_state_t state;
  irc_state_t next_state;

  logic [NUM_SRC-1:0] live;
  logic [NUM_SRC-1:0] is_vect;
  logic [NUM_SRC-1:0] fast_hit;
  logic [NUM_SRC-1:0] vect_hit;
  logic [NUM_SRC-1:0] plain_hit;
  logic [NUM_SLOT-1:0] slot_hit;
  logic pick_any;
  logic [LW-1:0] pick_idx;

  function automatic logic [SW-1:0] irc_slot_src(input logic [NUM_SLOT*SW-1:0] tbl, input int s);
    return tbl[s*SW +: SW];
  endfunction

  function automatic logic irc_src_ok(input logic [SW-1:0] idx);
    return int'(idx) < NUM_SRC;
  endfunction

  // classification is purely combinational on the live config, so a
  // reprogrammed class or slot shows at the next clock with clk_en high, without reset
  always_comb begin
    live = req_in & src_enable;
    is_vect = '0;
    slot_hit = '0;
    for (int s = 0; s < NUM_SLOT; s++) begin
      // an index past the last source names nothing, so the slot stays inert
      if (slot_enable[s] && irc_src_ok(irc_slot_src(slot_source, s))) begin
        if (!fast_select[irc_slot_src(slot_source, s)]) begin
          is_vect[irc_slot_src(slot_source, s)] = 1'b1;
          slot_hit[s] = live[irc_slot_src(slot_source, s)];
        end
      end
    end
    // fast overrides a slot mapping; anything left is plain normal
    fast_hit = live & fast_select;
    vect_hit = live & ~fast_select & is_vect;
    plain_hit = live & ~fast_select & ~is_vect;
  end

  irc_slot_pick #(
    .N(NUM_SLOT),
    .IW(LW)
  ) u_pick (
    .hits(slot_hit),
    .any(pick_any),
    .idx(pick_idx)
  );

  always_comb begin
    next_state = state;
    if (clk_en) begin
      next_state.fast_status = fast_hit;
      next_state.vect_status = vect_hit;
      next_state.plain_status = plain_hit;
      next_state.fast_req = |fast_hit;
      next_state.normal_req = |(vect_hit | plain_hit);
      next_state.vect_valid = pick_any;
      next_state.vect_slot = pick_idx;
      // fast wins over both normal kinds; vectored ahead of plain
      if (|fast_hit) begin
        next_state.present_class = irc_pkg::IRC_CLS_FAST;
      end else if (pick_any) begin
        next_state.present_class = irc_pkg::IRC_CLS_VECT;
      end else if (|plain_hit) begin
        next_state.present_class = irc_pkg::IRC_CLS_PLAIN;
      end else begin
        next_state.present_class = irc_pkg::IRC_CLS_NONE;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= '{default: '0, present_class: irc_pkg::IRC_CLS_NONE};
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    fast_req = state.fast_req;
    normal_req = state.normal_req;
    fast_status = state.fast_status;
    vect_status = state.vect_status;
    plain_status = state.plain_status;
    vect_valid = state.vect_valid;
    vect_slot = state.vect_slot;
    present_class = state.present_class;
  end

  // request words as the rules define them, kept apart from the datapath terms
  logic [NUM_SRC-1:0] chk_fast_src;
  logic [NUM_SRC-1:0] chk_norm_src;
  assign chk_fast_src = req_in & src_enable & fast_select;
  assign chk_norm_src = req_in & src_enable & ~fast_select;

  a_class_exclusive: assert property (@(posedge clk_sys) disable iff (!resetn)
    ((fast_status & vect_status) | (fast_status & plain_status) | (vect_status & plain_status)) == '0)
    else $error("a source sits in more than one class");

  a_config_effect: assert property (@(posedge clk_sys) disable iff (!resetn)
    resetn && clk_en && $changed(fast_select) |=> fast_status == $past(chk_fast_src))
    else $error("class change did not take effect next cycle");

  a_fast_first: assert property (@(posedge clk_sys) disable iff (!resetn)
    fast_req |-> present_class == irc_pkg::IRC_CLS_FAST)
    else $error("normal request presented while fast active");

  a_fast_merge: assert property (@(posedge clk_sys) disable iff (!resetn)
    resetn && clk_en |=> fast_req == (|$past(chk_fast_src)))
    else $error("fast output not the merge of fast sources");

  a_fast_word: assert property (@(posedge clk_sys) disable iff (!resetn)
    resetn && clk_en |=> fast_status == $past(chk_fast_src) && fast_req == (fast_status != '0))
    else $error("fast status word inconsistent");

  a_normal_merge: assert property (@(posedge clk_sys) disable iff (!resetn)
    resetn && clk_en |=> normal_req == (|$past(chk_norm_src)) && normal_req == ((vect_status | plain_status) != '0))
    else $error("normal output without a normal source");

  a_normal_drop: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && (req_in & src_enable & ~fast_select) == '0 |=> !normal_req)
    else $error("normal output stayed with no normal source");

  a_freeze_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    !clk_en |=> $stable(fast_req) && $stable(normal_req) && $stable(fast_status))
    else $error("state moved while clock enable low");

  a_freeze_class: assert property (@(posedge clk_sys) disable iff (!resetn)
    !clk_en |=> $stable(present_class) && $stable(vect_slot) && $stable(vect_status) && $stable(plain_status))
    else $error("class outputs moved while clock enable low");

  a_fast_drop: assert property (@(posedge clk_sys) disable iff (!resetn)
    clk_en && chk_fast_src == '0 |=> !fast_req && fast_status == '0)
    else $error("fast output stayed with no fast source");

  a_fast_present: assert property (@(posedge clk_sys) disable iff (!resetn)
    resetn && clk_en && chk_fast_src != '0 |=> present_class == irc_pkg::IRC_CLS_FAST)
    else $error("fast source not presented first");

  a_vect_order: assert property (@(posedge clk_sys) disable iff (!resetn)
    present_class == irc_pkg::IRC_CLS_VECT |-> !fast_req && vect_valid)
    else $error("vectored class presented out of order");

  a_plain_last: assert property (@(posedge clk_sys) disable iff (!resetn)
    present_class == irc_pkg::IRC_CLS_PLAIN |-> !fast_req && !vect_valid && plain_status != '0)
    else $error("plain class presented out of order");

  a_class_none: assert property (@(posedge clk_sys) disable iff (!resetn)
    present_class == irc_pkg::IRC_CLS_NONE |-> !fast_req && !normal_req)
    else $error("idle class while a request is up");

  a_vect_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
    vect_valid == (vect_status != '0))
    else $error("vectored flag disagrees with vectored word");

  a_slot_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
    !vect_valid |-> vect_slot == '0)
    else $error("slot index not zero while no slot hits");

  a_normal_rise: assert property (@(posedge clk_sys) disable iff (!resetn)
    resetn && clk_en && chk_norm_src != '0 |=> normal_req)
    else $error("normal source did not raise the normal output");
endmodule
`default_nettype wire

//--- verif/irc_core_model.sv
// core model that takes fast or normal requests
`default_nettype none
module irc_core_model (
  input wire logic fast_req,
  input wire logic normal_req,
  output logic [1:0] taken
);
  timeunit 1ns;
  timeprecision 1ns;
  // fast entry wins when both lines are up
  assign taken = fast_req ? 2'h1 : (normal_req ? 2'h2 : 2'h0);
endmodule
`default_nettype wire

//--- verif/irc_classifier_tb.sv
// self-checking bench for the interrupt request classifier
`default_nettype none
module irc_classifier_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] req_in = 8'h00;
  logic [7:0] src_enable = 8'h00;
  logic [7:0] fast_select = 8'h00;
  logic [3:0] slot_enable = 4'h0;
  logic [11:0] slot_source = 12'h000;
  logic fast_req, normal_req, vect_valid;
  logic [7:0] fast_status, vect_status, plain_status, act, map;
  logic [7:0] e_f = 8'h00;
  logic [7:0] e_v = 8'h00;
  logic [7:0] e_p = 8'h00;
  logic [1:0] vect_slot, taken;
  logic [1:0] e_slot = 2'h0;
  logic [1:0] e_cls = 2'h0;
  irc_pkg::irc_class_t present_class;
  logic [15:0] r = 16'h0026;
  int n_fail = 0;
  int tests_run = 0;
  int n = 0;
  irc_classifier #(.NUM_SRC(8), .NUM_SLOT(4)) uut (.clk_sys(clk_sys), .resetn(resetn),
    .clk_en(clk_en), .req_in(req_in), .src_enable(src_enable), .fast_select(fast_select),
    .slot_enable(slot_enable), .slot_source(slot_source), .fast_req(fast_req),
    .normal_req(normal_req), .fast_status(fast_status), .vect_status(vect_status),
    .plain_status(plain_status), .vect_valid(vect_valid), .vect_slot(vect_slot),
    .present_class(present_class));
  irc_core_model core (.fast_req(fast_req), .normal_req(normal_req), .taken(taken));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    for (int i = 0; i < 16; i++) s = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    return s;
  endfunction
  function automatic logic [7:0] exp_map(input logic [3:0] en, input logic [11:0] src);
    logic [7:0] m;
    m = 8'h00;
    for (int s = 0; s < 4; s++) begin
      if (en[s]) begin
        m[src[s*3+:3]] = 1'b1;
      end
    end
    return m;
  endfunction
  // lowest enabled slot naming a normal-class requester, 0 when none
  function automatic logic [1:0] exp_slot(input logic [3:0] en, input logic [11:0] src, input logic [7:0] nrm);
    logic [1:0] k;
    k = 2'h0;
    for (int s = 3; s >= 0; s--) begin
      if (en[s] && nrm[src[s*3+:3]]) begin
        k = 2'(s);
      end
    end
    return k;
  endfunction
  function automatic logic [1:0] exp_cls(input logic [7:0] f, input logic [7:0] v, input logic [7:0] p);
    if (f != 8'h00) begin
      return irc_pkg::IRC_CLS_FAST;
    end else if (v != 8'h00) begin
      return irc_pkg::IRC_CLS_VECT;
    end else if (p != 8'h00) begin
      return irc_pkg::IRC_CLS_PLAIN;
    end
    return irc_pkg::IRC_CLS_NONE;
  endfunction
  function automatic logic [3:0] exp_taken(input logic f, input logic nrm);
    return f ? 4'h1 : (nrm ? 4'h2 : 4'h0);
  endfunction
  task automatic chk_req(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_cls(input logic [3:0] g, input logic [3:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // expectation from the values the edge samples, then next stimulus
  always @(posedge clk_sys) begin
    if (!resetn) begin
      e_f = 8'h00;
      e_v = 8'h00;
      e_p = 8'h00;
      e_slot = 2'h0;
      e_cls = 2'h0;
    end else if (clk_en) begin
      act = req_in & src_enable;
      map = exp_map(slot_enable, slot_source);
      e_f = act & fast_select;
      e_v = act & ~fast_select & map;
      e_p = act & ~fast_select & ~map;
      e_slot = exp_slot(slot_enable, slot_source, act & ~fast_select);
      e_cls = exp_cls(e_f, e_v, e_p);
    end
    n++;
    r = lfsr(r);
    req_in <= (n >= 9 && n <= 11) ? 8'hff : r[7:0];
    src_enable <= r[15:8] | 8'h81;
    clk_en <= (n >= 9 && n <= 11) || r[3:0] != 4'h5;
    r = lfsr(r);
    fast_select <= (n == 10) ? 8'h01 : ((n == 11) ? 8'h00 : r[7:0] & r[15:8]);
    slot_enable <= (n == 10 || n == 11) ? 4'hf : r[3:0];
    r = lfsr(r);
    slot_source <= (n == 10 || n == 11) ? 12'h000 : r[11:0];
  end
  always @(negedge clk_sys) begin
    if (resetn) begin
      chk_req(fast_req, |e_f);
      chk_word(16'(fast_status), 16'(e_f));
      chk_req(normal_req, |(e_v | e_p));
      chk_word({vect_status, plain_status}, {e_v, e_p});
      chk_cls(4'({vect_valid, vect_slot}), 4'({|e_v, e_slot}));
      chk_cls(4'(present_class), 4'(e_cls));
      chk_cls(4'(taken), exp_taken(|e_f, |(e_v | e_p)));
    end else begin
      chk_req(fast_req | normal_req, 1'b0);
      chk_word({fast_status, vect_status}, 16'h0000);
      chk_word(16'(plain_status), 16'h0000);
      chk_cls(4'({vect_valid, vect_slot}), 4'h0);
      chk_cls(4'(present_class), 4'(irc_pkg::IRC_CLS_NONE));
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (400) @(posedge clk_sys);
    // mid-run reset: outputs clear at once, restart must be clean
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (400) @(posedge clk_sys);
    print_verdict();
  end
endmodule
`default_nettype wire
